//--- rtl/adc_serial_port.sv
// Serial result shifter, frame marker, read error flag and serial configuration port.
`timescale 1ns/1ps
module adc_serial_port #(
    parameter int RES_W = adc_serial_pkg::RESULT_W,
    parameter int CFG_BITS = adc_serial_pkg::CFG_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Static mode pins, asynchronous.
    input adc_serial_pkg::mode_pins_t modePins,
    input adc_serial_pkg::range_pins_t hwRangePins,
    // Conversion engine side, same clock.
    input wire logic convDone,
    input wire logic [RES_W-1:0] convResult,
    input wire logic readStart,
    // Chip select, active low, asynchronous.
    input wire logic chipSel_n,
    // Result clock pin split into in, out, enable.
    input wire logic resultShiftClockIn,
    output logic resultShiftClockOut,
    output logic resultShiftClockOe,
    // Serial result and frame.
    output logic serialResultOut,
    output logic frameMarker,
    output logic frameMarkerOe,
    output logic readErrorFlag,
    // Parallel pins covering bits 7..12.
    output logic [5:0] parallelShared,
    // Configuration port, asynchronous.
    input wire logic configSerialIn,
    input wire logic configShiftClock,
    input wire logic configPortSelect_n,
    // Effective settings.
    output adc_serial_pkg::range_pins_t activeRange,
    // Register port.
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic irq
);
    import adc_serial_pkg::*;

    // ************************************************************
    // Input synchronisers: two flops before any logic reads them.
    // ************************************************************
    logic [9:0] syncA_r, syncB_r;
    always_ff @(posedge sys_clk) begin
        syncA_r <= {modePins, chipSel_n, resultShiftClockIn, configSerialIn, configShiftClock};
        syncB_r <= syncA_r;
    end
    mode_pins_t mode;
    logic csN, extClk, cfgIn, cfgClk;
    assign {mode, csN, extClk, cfgIn, cfgClk} = syncB_r;
    logic cfgSelA_r, cfgSelN_r;
    always_ff @(posedge sys_clk) begin
        cfgSelA_r <= configPortSelect_n;
        cfgSelN_r <= cfgSelA_r;
    end
    // Range straps rarely move, but a strap flipped in use must not reach logic metastable.
    range_pins_t hwRangeA_r, hwRange_r;
    always_ff @(posedge sys_clk) begin
        hwRangeA_r <= hwRangePins;
        hwRange_r <= hwRangeA_r;
    end

    // Edge detectors on synchronised clocks.
    logic extClkD_r, cfgClkD_r;
    always_ff @(posedge sys_clk) begin
        extClkD_r <= extClk;
        cfgClkD_r <= cfgClk;
    end

    logic serialMode, masterMode, slaveMode;
    assign serialMode = mode.interfaceSelect;
    assign masterMode = serialMode && !mode.clockSourceSelect;
    assign slaveMode = serialMode && mode.clockSourceSelect;

    // Chosen active edge of an external clock, gated by chip select in slave mode.
    function automatic logic activeEdge(input logic now, input logic prev, input logic inv);
        activeEdge = inv ? (prev && !now) : (!prev && now);
    endfunction
    logic slaveEdge;
    assign slaveEdge = slaveMode && !csN && activeEdge(extClk, extClkD_r, mode.clockEdgeInvert);

    // ************************************************************
    // Master clock generator.
    // ************************************************************
    logic [7:0] divCnt_r;
    logic mClk_r;
    logic mTick;
    shift_state_t state_r;
    assign mTick = (divCnt_r == 8'(MCLK_HALF_CYC - 1));
    // The master clock runs only while a frame shifts so the host sees no stray edges.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_r != ST_SHIFT || !masterMode) begin
            divCnt_r <= 8'h00;
            mClk_r <= 1'b0;
        end else if (mTick) begin
            divCnt_r <= 8'h00;
            mClk_r <= !mClk_r;
        end else begin
            divCnt_r <= divCnt_r + 8'h01;
        end
    end
    // Data changes only on the falling master edge, so it is stable across both edges.
    logic mShift;
    assign mShift = masterMode && mTick && mClk_r;

    // ************************************************************
    // Result shifter.
    // ************************************************************
    logic [RES_W-1:0] shift_r;
    logic [5:0] bitCnt_r;
    logic shiftEv, errPulse;
    assign shiftEv = mShift || slaveEdge;
    // A finished conversion that lands mid-read drops the read only in slave mode, which also flags it.
    assign errPulse = convDone && slaveMode && (state_r == ST_SHIFT);
    logic [RES_W-1:0] fmtResult;
    // Format select high gives offset binary, low flips the MSB for twos complement.
    assign fmtResult = mode.outputFormatSelect ? convResult
        : {~convResult[RES_W-1], convResult[RES_W-2:0]};
    logic [RES_W-1:0] latched_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latched_r <= '0;
        end else if (convDone) begin
            latched_r <= fmtResult;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            shift_r <= '0;
            bitCnt_r <= 6'h00;
        end else if (errPulse) begin
            state_r <= ST_IDLE;
            bitCnt_r <= 6'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (readStart && serialMode) begin
                        state_r <= ST_SHIFT;
                        shift_r <= latched_r;
                        bitCnt_r <= 6'h00;
                    end
                end
                ST_SHIFT: begin
                    if (shiftEv) begin
                        shift_r <= {shift_r[RES_W-2:0], 1'b0};
                        bitCnt_r <= bitCnt_r + 6'h01;
                        if (bitCnt_r == 6'(RES_W - 1)) begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Pin outputs.
    // ************************************************************
    logic frameActive;
    assign frameActive = (state_r == ST_SHIFT);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            serialResultOut <= 1'b0;
            frameMarker <= 1'b0;
            readErrorFlag <= 1'b0;
        end else begin
            serialResultOut <= shift_r[RES_W-1];
            frameMarker <= frameActive ^ mode.frameMarkerPolarity;
            readErrorFlag <= errPulse;
        end
    end
    assign frameMarkerOe = masterMode;
    assign resultShiftClockOe = masterMode;
    assign resultShiftClockOut = mClk_r;
    // Shared pins are registered so the parallel bits never glitch on a mode change.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || serialMode) begin
            parallelShared <= 6'h00;
        end else begin
            parallelShared <= latched_r[SHARED_HI:SHARED_LO];
        end
    end

    // ************************************************************
    // Configuration port.
    // ************************************************************
    logic [CFG_BITS-1:0] cfgShift_r, cfgReg_r;
    logic [3:0] cfgCnt_r;
    logic cfgEdge, cfgLoad, swMode;
    assign swMode = serialMode && !mode.configSourceSelect;
    assign cfgEdge = swMode && !cfgSelN_r
        && activeEdge(cfgClk, cfgClkD_r, mode.clockEdgeInvert);
    assign cfgLoad = cfgEdge && (cfgCnt_r == 4'(CFG_BITS - 1));
    logic regCfgWr;
    assign regCfgWr = regWr && regAddr == ADDR_CFG;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || cfgSelN_r) begin
            cfgCnt_r <= 4'h0;
            cfgShift_r <= '0;
        end else if (cfgEdge) begin
            cfgShift_r <= {cfgShift_r[CFG_BITS-2:0], cfgIn};
            cfgCnt_r <= cfgLoad ? 4'h0 : cfgCnt_r + 4'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfgReg_r <= CFG_RESET;
        end else if (cfgLoad) begin
            cfgReg_r <= {cfgShift_r[CFG_BITS-2:0], cfgIn};
        end else if (regCfgWr) begin
            cfgReg_r <= CFG_BITS'(regWdata);
        end
    end
    // Effective range picks synchronised straps or the configuration register.
    range_pins_t activeRange_nxt;
    always_comb begin
        if (mode.configSourceSelect || !serialMode) begin
            activeRange_nxt = hwRange_r;
        end else begin
            activeRange_nxt.bipolar = cfgReg_r[B_BIPOLAR];
            activeRange_nxt.tenVolt = cfgReg_r[B_TEN];
            activeRange_nxt.powerDown = cfgReg_r[B_PDOWN];
        end
    end
    // The range leaves on a flop, costing one cycle after a source or strap change.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            activeRange <= '0;
        end else begin
            activeRange <= activeRange_nxt;
        end
    end

    // ************************************************************
    // Interrupt status, mask and register reads.
    // ************************************************************
    logic [3:0] stat_r, mask_r, evt;
    assign evt = (errPulse ? STAT_ERR : 4'h0) | (state_r == ST_DONE ? STAT_DONE : 4'h0)
        | (cfgLoad ? STAT_CFG : 4'h0);
    // A new event in the cycle of the clearing read survives.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stat_r <= STAT_RESET;
        end else if (regRd && regAddr == ADDR_STAT) begin
            stat_r <= evt;
        end else begin
            stat_r <= stat_r | evt;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mask_r <= MASK_RESET;
        end else if (regWr && regAddr == ADDR_MASK) begin
            mask_r <= regWdata[3:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                ADDR_STAT: regRdata <= {4'h0, stat_r};
                ADDR_MASK: regRdata <= {4'h0, mask_r};
                ADDR_CFG: regRdata <= 8'(cfgReg_r);
                ADDR_MODE: regRdata <= {2'h0, mode};
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end
    assign irq = |(stat_r & mask_r);

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    msb_first_a: assert property (frameActive && shiftEv && !errPulse
        |=> shift_r == {$past(shift_r[RES_W-2:0]), 1'b0})
        else $error("Shifter did not move toward the MSB.");
    data_stable_a: assert property (masterMode && mTick && !mClk_r
        |=> $stable(shift_r) && $stable(serialResultOut))
        else $error("Data changed on rising master edge.");
    clk_dir_a: assert property (resultShiftClockOe == masterMode)
        else $error("Clock direction wrong.");
    frame_only_master_a: assert property (!masterMode |-> !frameMarkerOe)
        else $error("Frame marker driven outside master mode.");
    frame_level_a: assert property (frameActive && !mode.frameMarkerPolarity
        && $stable(mode) |=> frameMarker)
        else $error("Frame marker not high during read.");
    frame_inv_a: assert property (frameActive && mode.frameMarkerPolarity
        && $stable(mode) |=> !frameMarker)
        else $error("Frame marker not low during read.");
    read_err_a: assert property (errPulse |=> readErrorFlag ##1 !readErrorFlag)
        else $error("Read error pulse malformed.");
    // An abort clears the bit count even while deselected, so it is left out here.
    cs_gate_a: assert property (slaveMode && csN && frameActive && !errPulse
        |=> $stable(bitCnt_r))
        else $error("Shift while chip select high.");
    cfg_gate_a: assert property (cfgSelN_r |=> cfgCnt_r == 4'h0)
        else $error("Config accepted while deselected.");
    cov_master_c: cover property (masterMode && state_r == ST_DONE);
    cov_slave_c: cover property (slaveMode && state_r == ST_DONE);
    cov_err_c: cover property (readErrorFlag);
    cov_cfg_c: cover property (cfgLoad);
endmodule // adc_serial_port

//--- rtl/adc_serial_pkg.sv
// Package with constants, types and the operation list for the serial read and config port.
// Operation
// - Result shifts out most significant bit first.
// - Format select picks binary or twos complement.
// - Master mode keeps bit valid both edges.
// - Slave updates on edge chosen by invert.
// - Clock source select sets clock pin direction.
// - Frame marker driven only in master mode.
// - Polarity low: marker high while data valid.
// - Polarity high: marker low while data valid.
// - Slave unfinished read at completion pulses error.
// - Software source uses serial configuration register.
// - Hardware source uses dedicated input pins.
// - Configuration bits captured on host clock.
// - Config clock edge chosen by invert input.
// - Parallel mode drives bits 7..12 on pins.
// - Source low master, high slave.
// - Chip select gates external clock in slave.
// - Config port accepts only while selected.
package adc_serial_pkg;
    // ************************************************************
    // Widths and timing.
    // ************************************************************
    localparam int RESULT_W = 14;
    localparam int CFG_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MCLK_HALF_NS = 40;
    localparam int MCLK_HALF_CYC = (MCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERR_PULSE_CYC = 1;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
    localparam int SHARED_LO = 7;
    localparam int SHARED_HI = 12;
    localparam logic [3:0] STAT_ERR = 4'h1;
    localparam logic [3:0] STAT_DONE = 4'h2;
    localparam logic [3:0] STAT_CFG = 4'h4;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [1:0] ADDR_STAT = 2'h0;
    localparam logic [1:0] ADDR_MASK = 2'h1;
    localparam logic [1:0] ADDR_CFG = 2'h2;
    localparam logic [1:0] ADDR_MODE = 2'h3;
    localparam int B_BIPOLAR = 0;
    localparam int B_TEN = 1;
    localparam int B_PDOWN = 2;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef struct packed {
        logic interfaceSelect;
        logic clockSourceSelect;
        logic clockEdgeInvert;
        logic frameMarkerPolarity;
        logic configSourceSelect;
        logic outputFormatSelect;
    } mode_pins_t;

    typedef struct packed {
        logic bipolar;
        logic tenVolt;
        logic powerDown;
    } range_pins_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} shift_state_t;
endpackage

//--- testbench/adc_host_model.sv
// Host serial port model: configuration writer and result reader in master and slave mode.
`timescale 1ns/1ps
module adc_host_model (
    // Clock.
    input wire logic sys_clk,
    // Result side.
    input wire logic serialResultOut,
    input wire logic resultShiftClockOut,
    input wire logic frameMarker,
    output logic resultShiftClockIn,
    output logic chipSel_n,
    // Configuration side.
    output logic configSerialIn,
    output logic configShiftClock,
    output logic configPortSelect_n
);
    // ****************************************
    // Host serial transfers at 8 MHz.
    // ****************************************
    localparam realtime HALF = 62.5;

    // Idle levels; the clocks stand still outside frames.
    initial begin
        resultShiftClockIn = 1'b0;
        chipSel_n = 1'b1;
        configSerialIn = 1'b0;
        configShiftClock = 1'b0;
        configPortSelect_n = 1'b1;
    end

    // Clock level is settled before select falls, so no stray edge is counted.
    task automatic send_cfg(input logic [7:0] val, input logic inv, input logic sel);
        configShiftClock <= inv;
        #HALF configPortSelect_n <= ~sel;
        for (int i = 7; i >= 0; i--) begin
            configSerialIn <= val[i];
            #HALF configShiftClock <= ~inv;
            #HALF configShiftClock <= inv;
        end
        #HALF configPortSelect_n <= 1'b1;
        configSerialIn <= ~val[0];
    endtask

    // Samples each bit at the same instant as it drives the active edge that replaces it.
    task automatic slave_read(input logic inv, input int gated, input int nbits,
                              output logic [13:0] bits);
        bits = '0;
        resultShiftClockIn <= inv;
        chipSel_n <= 1'b1;
        repeat (gated) begin
            #HALF resultShiftClockIn <= ~inv;
            #HALF resultShiftClockIn <= inv;
        end
        chipSel_n <= 1'b0;
        for (int i = 13; i > 13 - nbits; i--) begin
            #HALF bits[i] = serialResultOut;
            resultShiftClockIn <= ~inv;
            #HALF resultShiftClockIn <= inv;
        end
        #HALF chipSel_n <= 1'b1;
    endtask

    // Takes data and frame level at each rising edge of the device's clock.
    task automatic master_read(output logic [13:0] bits, output logic [13:0] marks,
                               output logic ok);
        int n;
        int guard;
        logic prev;
        n = 0;
        guard = 0;
        prev = resultShiftClockOut;
        bits = '0;
        marks = '0;
        while (n < 14 && guard < 2000) begin
            @(posedge sys_clk);
            #1 guard++;
            if (resultShiftClockOut && !prev) begin
                bits[13 - n] = serialResultOut;
                marks[13 - n] = frameMarker;
                n++;
            end
            prev = resultShiftClockOut;
        end
        ok = (n == 14);
    endtask
endmodule // adc_host_model

//--- testbench/adc_serial_port_bench.sv
// Self-checking bench for the serial read and configuration port.
`timescale 1ns/1ps
module adc_serial_port_bench;
    import adc_serial_pkg::*;
    // ****************************************
    // Stimulus, instances and checking.
    // ****************************************
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    mode_pins_t modePins = '0;
    range_pins_t hwRangePins = 3'b011;
    logic convDone = 1'b0;
    logic [RESULT_W-1:0] convResult = '0;
    logic readStart = 1'b0;
    logic [1:0] regAddr = '0;
    logic [7:0] regWdata = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic chipSel_n, resultShiftClockIn, configSerialIn, configShiftClock, configPortSelect_n;
    logic resultShiftClockOut, resultShiftClockOe, serialResultOut, frameMarker, frameMarkerOe;
    logic readErrorFlag, irq;
    logic [5:0] parallelShared;
    logic [7:0] regRdata;
    range_pins_t activeRange;
    int failCount = 0;
    int samplesChecked = 0;

    // Free-running system clock.
    always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    adc_serial_port adc_serial_port_i (.sys_clk, .sys_rst, .modePins, .hwRangePins, .convDone,
        .convResult, .readStart, .chipSel_n, .resultShiftClockIn, .resultShiftClockOut,
        .resultShiftClockOe, .serialResultOut, .frameMarker, .frameMarkerOe, .readErrorFlag,
        .parallelShared, .configSerialIn, .configShiftClock, .configPortSelect_n, .activeRange,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq);
    adc_host_model host_i (.sys_clk, .serialResultOut, .resultShiftClockOut, .frameMarker,
        .resultShiftClockIn, .chipSel_n, .configSerialIn, .configShiftClock, .configPortSelect_n);

    // Case equality, so an unknown never passes.
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (failCount == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Register port and engine pulses, each one cycle long.
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic load_result(input logic [13:0] v);
        @(posedge sys_clk);
        convDone <= 1'b1;
        convResult <= v;
        @(posedge sys_clk);
        convDone <= 1'b0;
    endtask
    task automatic start_read();
        @(posedge sys_clk);
        readStart <= 1'b1;
        @(posedge sys_clk);
        readStart <= 1'b0;
    endtask
    // Mode pins pass a synchroniser, so they are given time to land.
    task automatic set_mode(input logic [5:0] m);
        @(posedge sys_clk);
        modePins <= m;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic test_master(input logic pol, input logic fmt);
        logic [13:0] bits, marks;
        logic ok;
        logic [7:0] d;
        set_mode({1'b1, 1'b0, 1'b0, pol, 1'b1, fmt});
        check("clock oe", 1, resultShiftClockOe);
        check("marker oe", 1, frameMarkerOe);
        check("idle marker", pol, frameMarker);
        check("shared idle", 0, parallelShared);
        load_result(14'h2A5C);
        start_read();
        host_i.master_read(bits, marks, ok);
        if (!ok) begin
            failCount++;
            print_verdict();
        end
        check("master data", fmt ? 14'h2A5C : 14'h0A5C, bits);
        check("marker", {14{~pol}}, marks);
        repeat (20) @(posedge sys_clk);
        #1 check("end marker", pol, frameMarker);
        reg_read(ADDR_STAT, d);
        check("done status", STAT_DONE, d & STAT_DONE);
    endtask

    // Three edges with select high must not shift anything.
    task automatic test_slave(input logic inv);
        logic [13:0] bits;
        set_mode({1'b1, 1'b1, inv, 1'b0, 1'b1, 1'b1});
        check("clock oe", 0, resultShiftClockOe);
        check("marker oe", 0, frameMarkerOe);
        load_result(14'h1B39);
        start_read();
        host_i.slave_read(inv, 3, 14, bits);
        check("slave data", 14'h1B39, bits);
    endtask

    // A conversion lands in mid-read; the error raises the interrupt only when unmasked.
    task automatic test_abort();
        logic [13:0] bits;
        logic [7:0] d;
        logic [2:0] n;
        set_mode({1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1});
        reg_write(ADDR_MASK, 8'h00);
        reg_read(ADDR_STAT, d);
        load_result(14'h3FFF);
        start_read();
        host_i.slave_read(1'b0, 0, 5, bits);
        check("partial", 14'h3E00, bits);
        load_result(14'h0001);
        n = '0;
        repeat (4) begin
            #1 n = n + readErrorFlag;
            @(posedge sys_clk);
        end
        check("error pulse", 1, n);
        #1 check("irq masked", 0, irq);
        reg_write(ADDR_MASK, {4'h0, STAT_ERR});
        repeat (2) @(posedge sys_clk);
        #1 check("irq set", 1, irq);
        reg_read(ADDR_STAT, d);
        check("error status", STAT_ERR, d & STAT_ERR);
        repeat (2) @(posedge sys_clk);
        #1 check("irq clear", 0, irq);
    endtask

    task automatic test_config();
        logic [7:0] d;
        set_mode({1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        host_i.send_cfg(8'h05, 1'b0, 1'b1);
        repeat (4) @(posedge sys_clk);
        #1 check("sw range", 3'b101, activeRange);
        reg_read(ADDR_CFG, d);
        check("config reg", 8'h05, d);
        set_mode({1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1});
        host_i.send_cfg(8'h02, 1'b1, 1'b1);
        repeat (4) @(posedge sys_clk);
        #1 check("falling range", 3'b010, activeRange);
        host_i.send_cfg(8'h07, 1'b1, 1'b0);
        repeat (4) @(posedge sys_clk);
        #1 check("unselected", 3'b010, activeRange);
        reg_write(ADDR_CFG, 8'h04);
        repeat (2) @(posedge sys_clk);
        #1 check("written range", 3'b001, activeRange);
        reg_read(ADDR_MODE, d);
        check("mode readback", 8'h29, d);
        set_mode({1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1});
        check("hw range", 3'b011, activeRange);
    endtask

    // Main sequence: reset, then every scenario, then the verdict.
    initial begin
        logic [7:0] d;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check("idle rdata", 0, regRdata);
        reg_read(ADDR_STAT, d);
        check("status reset", STAT_RESET, d);
        reg_read(ADDR_MASK, d);
        check("mask reset", MASK_RESET, d);
        test_master(1'b0, 1'b1);
        test_master(1'b1, 1'b0);
        test_slave(1'b0);
        test_slave(1'b1);
        test_abort();
        test_config();
        set_mode({1'b0, 5'b00001});
        load_result(14'h2A5C);
        repeat (2) @(posedge sys_clk);
        #1 check("parallel", 6'h14, parallelShared);
        print_verdict();
    end
endmodule // adc_serial_port_bench
